/* core/lbi_cpu.sv */
/*
  Processor end of the multiplexed local bus: T1..T4 sequencing with wait
  states, halt, lock, test wait, hold and interrupt acknowledge.
  Assumes the system end keeps its rules; pin inputs arrive asynchronously.
*/
`timescale 1ns/1ns
module lbi_cpu #(
  parameter int QDEPTH = lbi_pkg::QUEUE_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        srst,
  lbi_if.cpu               bus,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [1:0]  req_kind,
  input  wire logic        req_io,
  input  wire logic [19:0] req_addr,
  input  wire logic [15:0] req_wdata,
  input  wire logic        req_word,
  output logic [15:0]      rsp_rdata,
  output logic             rsp_valid,
  input  wire logic        halt_cmd,
  input  wire logic        lock_prefix,
  input  wire logic        instr_end,
  input  wire logic        wait_cmd,
  input  wire logic        irq_enable,
  input  wire logic        queue_full,
  output logic             halted,
  output logic             waiting,
  output logic             irq_taken,
  output logic [9:0]       vector_ptr
);
  initial begin
    if (QDEPTH < 1) $error("lbi_cpu: queue depth must be at least one");
  end

  lbi_pkg::lbi_state_t state_r;
  logic [2:0]  rdy_s, test_s, nmi_s, irq_s, hreq_s, mode_s;
  logic        rdy, test_n, nmi_lvl, irq, hreq, max_mode;
  logic        nmi_prev_r, nmi_pend_r;
  logic        halt_r, halt_ale_r, wait_r, lock_r, lock_end_r;
  logic        ack_phase_r, ack_act_r, hold_r;
  logic [1:0]  kind_r;
  logic        io_r, word_r, ack_cyc_r;
  logic [19:0] addr_r;
  logic [15:0] wdata_r;
  logic        wake;

  // Three-flop input capture; a change counts when stages two and three agree
  always_ff @(posedge clk) begin
    rdy_s  <= {rdy_s[1:0],  bus.ready};
    test_s <= {test_s[1:0], bus.test_n};
    nmi_s  <= {nmi_s[1:0],  bus.nmi};
    irq_s  <= {irq_s[1:0],  bus.maskable_irq_req};
    hreq_s <= {hreq_s[1:0], bus.bus_request_grant};
    mode_s <= {mode_s[1:0], bus.mode_strap};
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      rdy <= 1'b0; test_n <= 1'b1; nmi_lvl <= 1'b0; irq <= 1'b0; hreq <= 1'b0;
      max_mode <= 1'b0;
    end else begin
      if (rdy_s[1] == rdy_s[2])   rdy <= rdy_s[2];
      if (test_s[1] == test_s[2]) test_n <= test_s[2];
      if (nmi_s[1] == nmi_s[2])   nmi_lvl <= nmi_s[2];
      if (irq_s[1] == irq_s[2])   irq <= irq_s[2];
      if (hreq_s[1] == hreq_s[2]) hreq <= hreq_s[2];
      if (mode_s[1] == mode_s[2]) max_mode <= ~mode_s[2];
    end
  end

  // Rising edge of NMI is latched; set wins over the clear on service
  always_ff @(posedge clk) begin
    if (srst) begin
      nmi_prev_r <= 1'b0;
      nmi_pend_r <= 1'b0;
    end else begin
      nmi_prev_r <= nmi_lvl;
      if (nmi_lvl && !nmi_prev_r) nmi_pend_r <= 1'b1;
      else if (start_ack)         nmi_pend_r <= 1'b0;
    end
  end

  assign wake = nmi_pend_r || (irq && irq_enable);

  logic idle;
  logic start_ack, start_halt, start_req, take_hold, bus_free;
  assign idle       = (state_r == lbi_pkg::LBI_IDLE);
  // A grant decided on this edge takes the bus before any cycle may start
  assign bus_free   = idle && !hold_r && !take_hold;
  // Interrupt response outranks queued work; in test wait, prefetch stops, and in test wait with a full queue all requests stop
  assign start_ack  = bus_free && (ack_phase_r || (wake && !ack_act_r));
  assign start_halt = bus_free && halt_ale_r && !start_ack;
  assign start_req  = bus_free && !start_ack && !start_halt && !halt_r && req_valid
                      && !(wait_r && (queue_full || req_kind == lbi_pkg::REQ_FETCH));
  // Hold is never granted mid-lock or between the two acknowledge cycles
  assign take_hold  = idle && hreq && !lock_r && !ack_phase_r && !ack_act_r;
  assign req_ready  = start_req;

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= lbi_pkg::LBI_IDLE;
      hold_r  <= 1'b0;
    end else begin
      case (state_r)
        lbi_pkg::LBI_IDLE: begin
          if (take_hold) begin
            state_r <= lbi_pkg::LBI_HOLD;
            hold_r  <= 1'b1;
          end else if (start_ack || start_halt || start_req) begin
            state_r <= lbi_pkg::LBI_T1;
          end
        end
        lbi_pkg::LBI_T1: state_r <= ack_cyc_r && kind_r == lbi_pkg::REQ_FETCH
                                    ? lbi_pkg::LBI_IDLE : lbi_pkg::LBI_T2;
        lbi_pkg::LBI_T2: state_r <= lbi_pkg::LBI_T3;
        lbi_pkg::LBI_T3,
        lbi_pkg::LBI_TW: state_r <= rdy ? lbi_pkg::LBI_T4 : lbi_pkg::LBI_TW;
        lbi_pkg::LBI_T4: state_r <= lbi_pkg::LBI_IDLE;
        lbi_pkg::LBI_HOLD: begin
          if (!hreq) begin
            state_r <= lbi_pkg::LBI_IDLE;
            hold_r  <= 1'b0;
          end
        end
        default: state_r <= lbi_pkg::LBI_IDLE;
      endcase
    end
  end

  // Cycle descriptor; a halt cycle is marked as a fetch kind with the ack flag
  always_ff @(posedge clk) begin
    if (srst) begin
      kind_r <= lbi_pkg::REQ_READ; io_r <= 1'b0; word_r <= 1'b0; ack_cyc_r <= 1'b0;
      addr_r <= '0; wdata_r <= '0;
    end else if (start_ack) begin
      kind_r <= lbi_pkg::REQ_READ; io_r <= 1'b1; word_r <= 1'b0; ack_cyc_r <= 1'b1;
    end else if (start_halt) begin
      kind_r <= lbi_pkg::REQ_FETCH; ack_cyc_r <= 1'b1;
    end else if (start_req) begin
      kind_r <= req_kind; io_r <= req_io; word_r <= req_word; ack_cyc_r <= 1'b0;
      addr_r <= req_addr; wdata_r <= req_wdata;
    end
  end

  logic is_halt_cyc, is_wr, is_ack, in_t2_t4, last_t4, strb_win;
  assign is_halt_cyc = ack_cyc_r && kind_r == lbi_pkg::REQ_FETCH;
  assign is_ack      = ack_cyc_r && !is_halt_cyc;
  assign is_wr       = !ack_cyc_r && kind_r == lbi_pkg::REQ_WRITE;
  assign in_t2_t4    = state_r inside {lbi_pkg::LBI_T2, lbi_pkg::LBI_T3,
                                       lbi_pkg::LBI_TW, lbi_pkg::LBI_T4};
  assign last_t4     = state_r == lbi_pkg::LBI_T4;
  // Next state is T2, T3 or a wait state: read-type strobes stand there
  assign strb_win    = state_r inside {lbi_pkg::LBI_T1, lbi_pkg::LBI_T2}
                       || (state_r inside {lbi_pkg::LBI_T3, lbi_pkg::LBI_TW} && !rdy);

  // Halt, test wait and interrupt acknowledge sequencing
  always_ff @(posedge clk) begin
    if (srst) begin
      halt_r <= 1'b0; halt_ale_r <= 1'b0; wait_r <= 1'b0;
      ack_phase_r <= 1'b0; ack_act_r <= 1'b0;
      irq_taken <= 1'b0; vector_ptr <= '0;
    end else begin
      irq_taken <= 1'b0;
      if (halt_cmd && !halt_r) begin
        halt_r <= 1'b1;
        halt_ale_r <= 1'b1;
      end else if (halt_r && wake) begin
        halt_r <= 1'b0;
        halt_ale_r <= 1'b0;
      end else if (start_halt) begin
        halt_ale_r <= 1'b0;
      end
      if (halt_r && state_r == lbi_pkg::LBI_HOLD && !hreq) halt_ale_r <= 1'b1;
      if (wait_cmd) wait_r <= 1'b1;
      else if (wait_r && !test_n) wait_r <= 1'b0;
      if (start_ack) ack_act_r <= 1'b1;
      if (is_ack && last_t4) begin
        if (!ack_phase_r) begin
          ack_phase_r <= 1'b1;
        end else begin
          ack_phase_r <= 1'b0;
          ack_act_r   <= 1'b0;
          irq_taken   <= 1'b1;
          vector_ptr  <= {bus.ad_in[7:0], 2'h0};
        end
      end
    end
  end

  // Lock: prefix-driven, or in max mode T2 of first to T2 of second acknowledge cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      lock_r <= 1'b0; lock_end_r <= 1'b0;
    end else begin
      if (lock_prefix) lock_r <= 1'b1;
      else if (lock_end_r && last_t4) lock_r <= 1'b0;
      if (lock_prefix) lock_end_r <= 1'b0;
      else if (lock_r && instr_end) lock_end_r <= 1'b1;
      if (lock_end_r && last_t4) lock_end_r <= 1'b0;
      if (max_mode && is_ack && state_r == lbi_pkg::LBI_T2)
        lock_r <= !ack_phase_r;
    end
  end

  // Read data: an odd-address byte comes back shifted to the low lane, else the whole word
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_rdata <= '0;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= last_t4 && !ack_cyc_r && !is_wr;
      if (last_t4 && !ack_cyc_r && !is_wr)
        rsp_rdata <= (!word_r && addr_r[0]) ? {8'h00, bus.ad_in[15:8]}
                                            : bus.ad_in;
    end
  end

  logic       min_mode, floating;
  logic [1:0] lanes;
  assign min_mode = !max_mode;
  assign floating = hold_r;
  assign lanes    = lbi_pkg::lane_sel(!(word_r || addr_r[0]), addr_r[0]);

  // Control outputs are registered so every pin is glitch-free
  always_ff @(posedge clk) begin
    if (srst) begin
      bus.ale <= 1'b0; bus.rd_n <= 1'b1; bus.wr_n <= 1'b1; bus.irq_ack_n <= 1'b1;
      bus.mem_io <= 1'b0; bus.high_byte_enable_n <= 1'b1; bus.addr_lat <= '0;
      bus.ad_out <= '0; bus.ad_oe_n <= 1'b1; bus.xcvr_direction <= 1'b0;
      bus.xcvr_enable_n <= 1'b1; bus.cycle_status_code <= lbi_pkg::ST_PASSIVE;
      bus.ctl_oe_n <= 1'b0; bus.lock_n <= 1'b1; bus.bus_grant <= 1'b0;
    end else begin
      bus.ctl_oe_n  <= floating;
      bus.bus_grant <= take_hold || (state_r == lbi_pkg::LBI_HOLD && hreq);
      bus.lock_n    <= !lock_r;
      bus.ale <= min_mode && (start_ack || start_halt || start_req);
      bus.mem_io <= (start_req) ? !req_io : (start_ack ? 1'b0 : bus.mem_io);
      if (start_req) begin
        bus.addr_lat           <= req_addr;
        bus.ad_out             <= req_addr[15:0];
        bus.ad_oe_n            <= 1'b0;
        bus.high_byte_enable_n <= !(req_word || req_addr[0]);
        bus.xcvr_direction     <= req_kind == lbi_pkg::REQ_WRITE;
      end else if (start_ack || start_halt) begin
        bus.ad_oe_n <= 1'b1;
        bus.xcvr_direction <= 1'b0;
      end else if (state_r == lbi_pkg::LBI_T1) begin
        if (is_wr) begin
          bus.ad_out <= lanes == 2'h2 ? {wdata_r[7:0], 8'h00} : wdata_r;
          bus.ad_oe_n <= 1'b0;
        end else begin
          bus.ad_oe_n <= 1'b1;
        end
      end else if (last_t4 || floating) begin
        bus.ad_oe_n <= 1'b1;
      end
      // Strobes are registered one state ahead, so they open with T2
      bus.wr_n <= !(min_mode && is_wr && (state_r == lbi_pkg::LBI_T1 ||
                   (in_t2_t4 && !last_t4 && state_r != lbi_pkg::LBI_T3) ||
                   (state_r == lbi_pkg::LBI_T3 && !rdy)));
      bus.rd_n <= !(min_mode && !ack_cyc_r && !is_wr && strb_win);
      bus.irq_ack_n <= !(min_mode && is_ack && strb_win);
      bus.xcvr_enable_n <= !(min_mode && strb_win && !is_halt_cyc);
      if (max_mode && state_r == lbi_pkg::LBI_IDLE) begin
        if (start_ack)       bus.cycle_status_code <= lbi_pkg::ST_IRQ_ACK;
        else if (start_halt) bus.cycle_status_code <= lbi_pkg::ST_HALT;
        else if (start_req) begin
          case (req_kind)
            lbi_pkg::REQ_WRITE: bus.cycle_status_code <= req_io ? lbi_pkg::ST_IO_WR
                                                                : lbi_pkg::ST_MEM_WR;
            lbi_pkg::REQ_FETCH: bus.cycle_status_code <= lbi_pkg::ST_CODE_RD;
            default:            bus.cycle_status_code <= req_io ? lbi_pkg::ST_IO_RD
                                                                : lbi_pkg::ST_MEM_RD;
          endcase
        end
      end else if (state_r == lbi_pkg::LBI_T3 || state_r == lbi_pkg::LBI_TW ||
                   state_r == lbi_pkg::LBI_T1 && is_halt_cyc || !max_mode) begin
        bus.cycle_status_code <= lbi_pkg::ST_PASSIVE;
      end
    end
  end

  assign halted  = halt_r;
  assign waiting = wait_r;
endmodule // lbi_cpu

/* core/lbi_if.sv */
/*
  Local bus carrier between the processor end and the system end.
  Assumes the bench resolves the shared data lines from the enables.
*/
`timescale 1ns/1ns
interface lbi_if;
  logic [19:0] addr_lat;
  logic [15:0] ad_out;
  logic        ad_oe_n;
  logic [15:0] ad_in;
  logic        ale;
  logic        mem_io;
  logic        rd_n;
  logic        wr_n;
  logic        irq_ack_n;
  logic        high_byte_enable_n;
  logic        xcvr_direction;
  logic        xcvr_enable_n;
  logic        ctl_oe_n;
  logic [2:0]  cycle_status_code;
  logic        lock_n;
  logic        ready;
  logic        test_n;
  logic        nmi;
  logic        maskable_irq_req;
  logic        bus_request_grant;
  logic        bus_grant;
  logic        mode_strap;

  modport cpu (
    output addr_lat, ad_out, ad_oe_n, ale, mem_io, rd_n, wr_n, irq_ack_n,
           high_byte_enable_n, xcvr_direction, xcvr_enable_n, ctl_oe_n,
           cycle_status_code, lock_n, bus_grant,
    input  ad_in, ready, test_n, nmi, maskable_irq_req, bus_request_grant, mode_strap
  );
  modport sys (
    input  addr_lat, ad_out, ad_oe_n, ale, mem_io, rd_n, wr_n, irq_ack_n,
           high_byte_enable_n, xcvr_direction, xcvr_enable_n, ctl_oe_n,
           cycle_status_code, lock_n, bus_grant,
    output ad_in, ready, test_n, nmi, maskable_irq_req, bus_request_grant, mode_strap
  );
endinterface

/* core/lbi_pkg.sv */
/*
  Shared constants and types for the local bus interface: cycle status codes,
  bus state encodings, byte-lane decoding and vector arithmetic.
  Assumes a single clock domain shared by both ends.
*/
package lbi_pkg;
  localparam int          ADDR_W       = 20;
  localparam int          DATA_W       = 16;
  localparam int          STAT_W       = 3;
  // Cycle status codes, active-low encoding as seen on the status pins
  localparam logic [2:0]  ST_IRQ_ACK   = 3'h0;
  localparam logic [2:0]  ST_IO_RD     = 3'h1;
  localparam logic [2:0]  ST_IO_WR     = 3'h2;
  localparam logic [2:0]  ST_HALT      = 3'h3;
  localparam logic [2:0]  ST_CODE_RD   = 3'h4;
  localparam logic [2:0]  ST_MEM_RD    = 3'h5;
  localparam logic [2:0]  ST_MEM_WR    = 3'h6;
  localparam logic [2:0]  ST_PASSIVE   = 3'h7;
  // Bus request kinds on the device user port
  localparam logic [1:0]  REQ_READ     = 2'h0;
  localparam logic [1:0]  REQ_WRITE    = 2'h1;
  localparam logic [1:0]  REQ_FETCH    = 2'h2;
  localparam int          VEC_SHIFT    = 2;
  localparam int          QUEUE_DEPTH  = 6;

  typedef enum logic [6:0] {
    LBI_IDLE = 7'h01,
    LBI_T1   = 7'h02,
    LBI_T2   = 7'h04,
    LBI_T3   = 7'h08,
    LBI_TW   = 7'h10,
    LBI_T4   = 7'h20,
    LBI_HOLD = 7'h40
  } lbi_state_t;

  // Byte lanes from high-byte enable and address bit 0: {high, low}
  function automatic logic [1:0] lane_sel(input logic bhe_n, input logic a0);
    lane_sel = {~bhe_n, ~a0};
  endfunction
endpackage

/* core/lbi_sys.sv */
/*
  System end of the local bus: address latch, a small word memory, an
  interrupt controller answering acknowledge cycles, and a max-mode status
  decoder that makes one ALE per new non-passive status, halt included.
  Assumes the processor end follows the bus timing; same clock.
*/
`timescale 1ns/1ns
module lbi_sys #(
  parameter int MEM_WORDS = 16,
  parameter int LATENCY   = 1
) (
  input  wire logic        clk,
  input  wire logic        srst,
  lbi_if.sys               bus,
  input  wire logic        min_mode_sel,
  input  wire logic        irq_in,
  input  wire logic [7:0]  irq_type,
  input  wire logic        nmi_in,
  input  wire logic        test_in_n,
  input  wire logic        hold_req,
  output logic             max_ale,
  output logic [19:0]      latched_addr
);
  localparam int AW = $clog2(MEM_WORDS);
  initial begin
    if (MEM_WORDS < 2 || LATENCY < 0 || LATENCY > 15) $error("lbi_sys: bad parameters");
  end

  logic [15:0] mem_r [MEM_WORDS];
  logic        ale_prev_r, ack_second_r, rd_prev_r;
  logic [3:0]  lat_cnt_r;
  logic [2:0]  stat_prev_r;
  logic [1:0]  lanes;
  logic [AW-1:0] idx;

  assign lanes = lbi_pkg::lane_sel(bus.high_byte_enable_n, latched_addr[0]);
  assign idx   = latched_addr[AW:1];

  // Address captured on the falling edge of ALE
  always_ff @(posedge clk) begin
    if (srst) begin
      ale_prev_r   <= 1'b0;
      latched_addr <= '0;
    end else begin
      ale_prev_r <= bus.ale || max_ale;
      if (ale_prev_r && !(bus.ale || max_ale)) latched_addr <= bus.addr_lat;
    end
  end

  // Max-mode decoder: one ALE per new non-passive status, halt included
  always_ff @(posedge clk) begin
    if (srst) begin
      stat_prev_r <= lbi_pkg::ST_PASSIVE;
      max_ale     <= 1'b0;
    end else begin
      stat_prev_r <= bus.cycle_status_code;
      max_ale <= !min_mode_sel && stat_prev_r == lbi_pkg::ST_PASSIVE &&
                 bus.cycle_status_code != lbi_pkg::ST_PASSIVE;
    end
  end

  // Ready follows a read or acknowledge strobe after a settable delay; a low write strobe gives ready at once
  always_ff @(posedge clk) begin
    if (srst) begin
      lat_cnt_r <= '0;
      rd_prev_r <= 1'b1;
    end else begin
      rd_prev_r <= bus.rd_n && bus.irq_ack_n && bus.wr_n;
      if (!rd_prev_r && lat_cnt_r != 4'(LATENCY)) lat_cnt_r <= lat_cnt_r + 4'h1;
      else if (rd_prev_r) lat_cnt_r <= '0;
    end
  end

  // Acknowledge pairing and memory writes in the lanes selected
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_second_r <= 1'b0;
      for (int i = 0; i < MEM_WORDS; i++) mem_r[i] <= '0;
    end else begin
      if (bus.irq_ack_n && !rd_prev_r && !bus.wr_n) begin
        if (lanes[0]) mem_r[idx][7:0]  <= bus.ad_out[7:0];
        if (lanes[1]) mem_r[idx][15:8] <= bus.ad_out[15:8];
      end
      if (!bus.irq_ack_n && rd_prev_r) ack_second_r <= !ack_second_r;
    end
  end

  // ad_in loads only while a read or acknowledge strobe is low and holds its value otherwise
  always_ff @(posedge clk) begin
    if (srst) begin
      bus.ad_in <= '0;
    end else if (!bus.rd_n) begin
      bus.ad_in <= mem_r[idx];
    end else if (!bus.irq_ack_n) begin
      // Parity already toggled after the first edge of a strobe; type only in the second
      bus.ad_in <= (ack_second_r ^ rd_prev_r) ? 16'h0000 : {8'h00, irq_type};
    end
  end

  assign bus.ready             = lat_cnt_r == 4'(LATENCY) || !bus.wr_n;
  assign bus.test_n            = test_in_n;
  assign bus.nmi               = nmi_in;
  assign bus.maskable_irq_req  = irq_in;
  assign bus.bus_request_grant = hold_req;
  assign bus.mode_strap        = min_mode_sel;
endmodule // lbi_sys

/* tb/lbi_bus_asserts.sv */
/*
  Concurrent checks on the local bus between the processor and system ends.
  Assumes one clock and srst synchronous, active high; sees only bus signals.
*/
`timescale 1ns/1ns
module lbi_bus_asserts (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       ale,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       irq_ack_n,
  input wire logic       ad_oe_n,
  input wire logic       mem_io,
  input wire logic       ctl_oe_n,
  input wire logic       bus_grant,
  input wire logic       lock_n,
  input wire logic       mode_strap,
  input wire logic [2:0] cycle_status_code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Parity of acknowledge strobes, so the first of a pair can be told apart
  logic ack_odd_r;
  always_ff @(posedge clk) begin
    if (srst) ack_odd_r <= 1'b0;
    else if ($fell(irq_ack_n)) ack_odd_r <= ~ack_odd_r;
  end

  sequence s_low2(sig);
    !sig [*2];
  endsequence

  chk_ale_single: assert property (ale |=> !ale)
    else $error("ale wider than one cycle");
  chk_rd_from_t2: assert property ($fell(rd_n) |-> $past(ale) ##0 s_low2(rd_n))
    else $error("read strobe not at T2 through T3");
  chk_wr_from_t2: assert property ($fell(wr_n) |-> $past(ale) ##0 s_low2(wr_n))
    else $error("write strobe not at T2 through T3");
  chk_rd_bus_off: assert property (!rd_n |-> ad_oe_n)
    else $error("address driven during read");
  chk_wr_data_on: assert property (!wr_n |-> !ad_oe_n)
    else $error("write data not driven");
  chk_mio_stable: assert property (ale ##1 !(rd_n && wr_n && irq_ack_n)
                                   |-> $stable(mem_io) [*3])
    else $error("memory select moved in cycle");
  chk_hold_float: assert property (bus_grant && $past(bus_grant) |-> ctl_oe_n && ad_oe_n)
    else $error("outputs driven in hold");
  // Grant and lock release are registered on the same edge
  chk_grant_unlocked: assert property ($rose(bus_grant) |-> lock_n)
    else $error("grant while locked");
  chk_max_quiet: assert property (!mode_strap && $past(mode_strap, 4) == 1'b0
                                  |-> rd_n && wr_n && irq_ack_n)
    else $error("strobe in max mode");
  chk_halt_code: assert property (cycle_status_code == lbi_pkg::ST_HALT
                                  |=> cycle_status_code == lbi_pkg::ST_PASSIVE)
    else $error("halt code not single cycle");
  chk_ack_pair: assert property ($fell(irq_ack_n) && !ack_odd_r |-> ##[2:12] $fell(irq_ack_n))
    else $error("second acknowledge missing");
endmodule // lbi_bus_asserts

/* tb/tb_cpu_local_bus_interface.sv */
/*
  Self-checking bench joining processor and system ends over the bus carrier.
  Assumes a 250 MHz clock and srst synchronous, active high.
*/
`timescale 1ns/1ns
module tb_cpu_local_bus_interface;
  logic        clk, srst, req_valid, req_ready, req_io, req_word, rsp_valid;
  logic        halt_cmd, lock_prefix, instr_end, wait_cmd, irq_enable, queue_full;
  logic        halted, waiting, irq_taken, min_mode_sel, irq_in, nmi_in, test_in_n;
  logic        hold_req, max_ale;
  logic [1:0]  req_kind;
  logic [19:0] req_addr, latched_addr;
  logic [15:0] req_wdata, rsp_rdata, r;
  logic [9:0]  vector_ptr;
  logic [7:0]  irq_type;
  int          num_errors, comparisons, ale_cnt, strb_cnt, ack_cnt, max_cnt;

  lbi_if bus_if();
  lbi_cpu u_lbi_cpu (.clk, .srst, .bus(bus_if), .req_valid, .req_ready, .req_kind, .req_io,
    .req_addr, .req_wdata, .req_word, .rsp_rdata, .rsp_valid, .halt_cmd, .lock_prefix,
    .instr_end, .wait_cmd, .irq_enable, .queue_full, .halted, .waiting, .irq_taken,
    .vector_ptr);
  lbi_sys u_lbi_sys (.clk, .srst, .bus(bus_if), .min_mode_sel, .irq_in, .irq_type, .nmi_in,
    .test_in_n, .hold_req, .max_ale, .latched_addr);
  lbi_bus_asserts u_lbi_bus_asserts (.clk, .srst, .ale(bus_if.ale), .rd_n(bus_if.rd_n),
    .wr_n(bus_if.wr_n), .irq_ack_n(bus_if.irq_ack_n), .ad_oe_n(bus_if.ad_oe_n),
    .mem_io(bus_if.mem_io), .ctl_oe_n(bus_if.ctl_oe_n), .bus_grant(bus_if.bus_grant),
    .lock_n(bus_if.lock_n), .mode_strap(bus_if.mode_strap),
    .cycle_status_code(bus_if.cycle_status_code));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (bus_if.ale === 1'b1) ale_cnt++;
    if (max_ale === 1'b1) max_cnt++;
    if (!(bus_if.rd_n && bus_if.wr_n && bus_if.irq_ack_n)) strb_cnt++;
    if (bus_if.irq_ack_n === 1'b0 && $past(bus_if.irq_ack_n) === 1'b1) ack_cnt++;
  end

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask

  task automatic results();
    $display("comparisons=%0d errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Request is held from one rising edge until the edge where req_ready is seen
  task automatic bus_op(input logic [1:0] k, input logic [19:0] a, input logic [15:0] d,
                        input logic w, output logic [15:0] rd);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind  <= k;
    req_addr  <= a;
    req_wdata <= d;
    req_word  <= w;
    @(negedge clk);
    for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b0;
    rd = 'x;
    for (n = 0; n < 30 && rsp_valid !== 1'b1; n++) @(negedge clk);
    if (rsp_valid === 1'b1) rd = rsp_rdata;
  endtask

  task automatic t_mem();
    bus_op(lbi_pkg::REQ_WRITE, 20'h00004, 16'h1234, 1'b1, r);
    bus_op(lbi_pkg::REQ_WRITE, 20'h00005, 16'h00ab, 1'b0, r);
    bus_op(lbi_pkg::REQ_READ, 20'h00004, 16'h0000, 1'b1, r);
    chk(r, 16'hab34, "odd byte lane");
    chk(latched_addr, 20'h00004, "latched address");
    bus_op(lbi_pkg::REQ_READ, 20'h00005, 16'h0000, 1'b0, r);
    chk(r[7:0], 8'hab, "odd byte read");
    bus_op(lbi_pkg::REQ_WRITE, 20'h00006, 16'hffff, 1'b1, r);
    bus_op(lbi_pkg::REQ_WRITE, 20'h00006, 16'h0055, 1'b0, r);
    bus_op(lbi_pkg::REQ_FETCH, 20'h00006, 16'h0000, 1'b1, r);
    chk(r, 16'hff55, "even byte lane");
    $display("test memory done");
  endtask

  task automatic t_lock();
    @(posedge clk) lock_prefix <= 1'b1;
    @(posedge clk) lock_prefix <= 1'b0;
    hold_req <= 1'b1;
    repeat (10) @(posedge clk);
    chk(bus_if.bus_grant, 1'b0, "grant during lock");
    chk(bus_if.lock_n, 1'b0, "lock not asserted");
    instr_end <= 1'b1;
    @(posedge clk) instr_end <= 1'b0;
    // Lock ends with the last bus cycle of the locked instruction
    bus_op(lbi_pkg::REQ_WRITE, 20'h00008, 16'h5a5a, 1'b1, r);
    chk(bus_if.lock_n, 1'b1, "lock not released");
    chk(bus_if.bus_grant, 1'b1, "held request lost");
    @(posedge clk) hold_req <= 1'b0;
    repeat (10) @(posedge clk);
    $display("test lock done");
  endtask

  task automatic t_wait();
    queue_full <= 1'b1;
    test_in_n  <= 1'b1;
    @(posedge clk) wait_cmd <= 1'b1;
    @(posedge clk) wait_cmd <= 1'b0;
    // A fetch offered while the queue is full must not start
    req_valid <= 1'b1;
    req_kind  <= lbi_pkg::REQ_FETCH;
    @(negedge clk) ale_cnt = 0;
    repeat (20) @(posedge clk);
    chk(waiting, 1'b1, "wait ended early");
    chk(ale_cnt, 0, "bus cycle in wait");
    chk(req_ready, 1'b0, "request taken in wait");
    req_valid <= 1'b0;
    hold_req <= 1'b1;
    repeat (10) @(posedge clk);
    chk(bus_if.bus_grant, 1'b1, "no hold in wait");
    hold_req <= 1'b0;
    repeat (6) @(posedge clk);
    test_in_n <= 1'b0;
    repeat (12) @(posedge clk);
    chk(waiting, 1'b0, "wait not ended");
    $display("test wait done");
  endtask

  task automatic t_irq();
    int n;
    irq_enable <= 1'b1;
    irq_type   <= 8'h21;
    irq_in     <= 1'b1;
    @(negedge clk) ack_cnt = 0;
    for (n = 0; n < 50 && bus_if.irq_ack_n !== 1'b0; n++) @(negedge clk);
    @(posedge clk) irq_in <= 1'b0;
    for (n = 0; n < 50 && irq_taken !== 1'b1; n++) @(negedge clk);
    chk(vector_ptr, 10'h084, "vector pointer");
    chk(ack_cnt, 2, "acknowledge count");
    irq_enable <= 1'b0;
    repeat (10) @(posedge clk);
    $display("test interrupt done");
  endtask

  task automatic t_halt();
    @(negedge clk) begin
      ale_cnt = 0;
      strb_cnt = 0;
    end
    @(posedge clk) halt_cmd <= 1'b1;
    @(posedge clk) halt_cmd <= 1'b0;
    repeat (10) @(posedge clk);
    chk(ale_cnt, 1, "halt ale count");
    chk(strb_cnt, 0, "strobe on halt");
    irq_in <= 1'b1;
    repeat (10) @(posedge clk);
    chk(halted, 1'b1, "masked request woke");
    irq_in <= 1'b0;
    nmi_in <= 1'b1;
    repeat (6) @(posedge clk);
    nmi_in <= 1'b0;
    repeat (20) @(posedge clk);
    chk(halted, 1'b0, "nmi did not wake");
    $display("test halt done");
  endtask

  task automatic t_max();
    min_mode_sel <= 1'b0;
    do_reset();
    @(negedge clk) begin
      max_cnt = 0;
      strb_cnt = 0;
    end
    @(posedge clk) halt_cmd <= 1'b1;
    @(posedge clk) halt_cmd <= 1'b0;
    repeat (10) @(posedge clk);
    chk(max_cnt, 1, "max halt ale count");
    chk(strb_cnt, 0, "strobe in max mode");
    $display("test max mode done");
  endtask

  initial begin
    {srst, req_valid, req_io, req_word, halt_cmd, lock_prefix, instr_end} = '0;
    {wait_cmd, irq_enable, queue_full, irq_in, nmi_in, hold_req} = '0;
    {req_kind, req_addr, req_wdata, irq_type} = '0;
    {min_mode_sel, test_in_n} = 2'h3;
    {num_errors, comparisons, ale_cnt, strb_cnt, ack_cnt, max_cnt} = '0;
    do_reset();
    t_mem();
    t_lock();
    t_wait();
    t_irq();
    t_halt();
    t_max();
    results();
  end

  // Whole sequence needs about 400 cycles; the limit leaves wide margin
  initial begin
    #40000;
    num_errors++;
    results();
  end
endmodule // tb_cpu_local_bus_interface
